// File: src/fcs_ctrl.sv
// host controller issuing command sequences to the parallel flash
`include "fcs_params.svh"
module fcs_ctrl
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // user request
  input  wire logic              req_valid,
  input  wire fcs_pkg::fcs_req_s req,
  output logic                   req_ready,
  // user answer
  output logic                   rsp_valid,
  output logic [15:0]            rsp_data,
  output logic                   rsp_fail,
  // flash pins
  output logic                   ce_b,
  output logic                   we_b,
  output logic                   oe_b,
  output logic [19:0]            addr,
  output logic [15:0]            dq_out,
  output logic                   dq_oe_b,
  input  wire logic [15:0]       dq_in
);
  // ---------------------------------------------
  // sequence tables
  // ---------------------------------------------
  function automatic fcs_pkg::fcs_cyc_s cyc(input logic [19:0] a, input logic [7:0] d);
    cyc = '{addr: a, data: {8'h00, d}, wr: 1'b1};
  endfunction

  function automatic logic [2:0] seq_len(input fcs_pkg::fcs_op_e op);
    case (op)
      fcs_pkg::OP_READ, fcs_pkg::OP_RESET, fcs_pkg::OP_QUERY,
      fcs_pkg::OP_SUSPEND, fcs_pkg::OP_RESUME, fcs_pkg::OP_SECT_ADD: seq_len = 3'd1;
      fcs_pkg::OP_BYP_PROG, fcs_pkg::OP_BYP_EXIT:                  seq_len = 3'd2;
      fcs_pkg::OP_ID_ENTER, fcs_pkg::OP_BYP_ENT:                   seq_len = 3'd3;
      fcs_pkg::OP_PROGRAM:                                          seq_len = 3'd4;
      default:                                                      seq_len = 3'd6;
    endcase
  endfunction

  function automatic fcs_pkg::fcs_cyc_s seq_cyc(input fcs_pkg::fcs_req_s r, input logic [2:0] i);
    logic [19:0] sa;
    sa = {r.addr[19:`FCS_SECT_LSB], 12'h000};
    seq_cyc = cyc(`FCS_UNLOCK1, `FCS_D_AA);
    if (i == 3'd1)
      seq_cyc = cyc(`FCS_UNLOCK2, `FCS_D_55);
    case (r.op)
      fcs_pkg::OP_READ:     seq_cyc = '{addr: r.addr, data: 16'h0000, wr: 1'b0};
      fcs_pkg::OP_RESET:    seq_cyc = cyc(20'h00000, `FCS_D_RESET);
      fcs_pkg::OP_QUERY:    seq_cyc = cyc(`FCS_QUERY_ADDR, `FCS_D_QUERY);
      fcs_pkg::OP_SUSPEND:  seq_cyc = cyc(20'h00000, `FCS_D_SUSP);
      fcs_pkg::OP_RESUME:   seq_cyc = cyc(20'h00000, `FCS_D_SECT);
      fcs_pkg::OP_SECT_ADD: seq_cyc = cyc(sa, `FCS_D_SECT);
      fcs_pkg::OP_ID_ENTER: if (i == 3'd2) seq_cyc = cyc(`FCS_UNLOCK1, `FCS_D_ID);
      fcs_pkg::OP_BYP_ENT:  if (i == 3'd2) seq_cyc = cyc(`FCS_UNLOCK1, `FCS_D_BYPASS);
      fcs_pkg::OP_BYP_EXIT: seq_cyc = cyc(20'h00000, (i == 3'd0) ? `FCS_D_ID : `FCS_D_ZERO);
      fcs_pkg::OP_BYP_PROG:
        seq_cyc = (i == 3'd0) ? cyc(20'h00000, `FCS_D_PROG)
                              : '{addr: r.addr, data: r.data, wr: 1'b1};
      fcs_pkg::OP_PROGRAM:
        if (i == 3'd2)
          seq_cyc = cyc(`FCS_UNLOCK1, `FCS_D_PROG);
        else if (i == 3'd3)
          seq_cyc = '{addr: r.addr, data: r.data, wr: 1'b1};
      default:
        if (i == 3'd2)
          seq_cyc = cyc(`FCS_UNLOCK1, `FCS_D_SETUP);
        else if (i == 3'd3)
          seq_cyc = cyc(`FCS_UNLOCK1, `FCS_D_AA);
        else if (i == 3'd4)
          seq_cyc = cyc(`FCS_UNLOCK2, `FCS_D_55);
        else if (i == 3'd5)
          seq_cyc = (r.op == fcs_pkg::OP_CHIP_ER) ? cyc(`FCS_UNLOCK1, `FCS_D_CHIP)
                                                  : cyc(sa, `FCS_D_SECT);
    endcase
  endfunction

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  fcs_pkg::fcs_st_e  st_q, st_d;
  fcs_pkg::fcs_req_s req_q;
  logic [2:0]        idx_q;
  logic [2:0]        len_q;
  logic [1:0]        cnt_q;
  logic [15:0]       rdat_q;
  logic              rvld_q;
  logic              fail_q;
  logic              polls_q;
  fcs_pkg::fcs_cyc_s cur_c;

  wire take       = req_valid && (st_q == fcs_pkg::ST_IDLE);
  wire phase_done = (cnt_q == 2'(`FCS_PHASE_CYC - 1));
  wire last_cyc   = (idx_q == len_q - 3'd1);
  wire poll_op    = (req_q.op == fcs_pkg::OP_PROGRAM) || (req_q.op == fcs_pkg::OP_BYP_PROG) ||
                    (req_q.op == fcs_pkg::OP_CHIP_ER) || (req_q.op == fcs_pkg::OP_SECT_ER);
  wire erase_op   = (req_q.op == fcs_pkg::OP_CHIP_ER) || (req_q.op == fcs_pkg::OP_SECT_ER);
  wire poll_want  = erase_op ? 1'b1 : req_q.data[`FCS_POLL_BIT];
  wire poll_ok    = dq_in[`FCS_POLL_BIT] == poll_want;
  wire poll_lim   = dq_in[`FCS_LIMIT_BIT];
  wire read_gap   = (st_q == fcs_pkg::ST_POLL) && phase_done;

  assign cur_c     = seq_cyc(req_q, idx_q);
  assign req_ready = (st_q == fcs_pkg::ST_IDLE);
  assign rsp_valid = rvld_q;
  assign rsp_data  = rdat_q;
  assign rsp_fail  = fail_q;

  // ---------------------------------------------
  // sequencer
  // ---------------------------------------------
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      fcs_pkg::ST_IDLE:  if (req_valid) st_d = fcs_pkg::ST_SETUP;
      fcs_pkg::ST_SETUP: if (phase_done) st_d = cur_c.wr ? fcs_pkg::ST_WE : fcs_pkg::ST_RD;
      fcs_pkg::ST_WE:    if (phase_done) st_d = fcs_pkg::ST_HOLD;
      fcs_pkg::ST_HOLD:
        if (phase_done)
          st_d = !last_cyc ? fcs_pkg::ST_SETUP : (poll_op ? fcs_pkg::ST_POLL : fcs_pkg::ST_IDLE);
      fcs_pkg::ST_RD:    if (phase_done) st_d = fcs_pkg::ST_IDLE;
      fcs_pkg::ST_POLL:  if (phase_done && (poll_ok || poll_lim)) st_d = fcs_pkg::ST_RD;
      default:           st_d = fcs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q   <= fcs_pkg::ST_IDLE;
      req_q  <= '0;
      idx_q  <= 3'd0;
      len_q  <= 3'd1;
      cnt_q  <= 2'd0;
      rdat_q <= 16'h0000;
      rvld_q <= 1'b0;
      fail_q <= 1'b0;
      polls_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      rvld_q <= 1'b0;
      cnt_q  <= (st_q == fcs_pkg::ST_IDLE || phase_done) ? 2'd0 : cnt_q + 2'd1;
      if (take)
      begin
        req_q  <= req;
        len_q  <= seq_len(req.op);
        idx_q  <= 3'd0;
        fail_q <= 1'b0;
        polls_q <= 1'b0;
      end
      if (st_q == fcs_pkg::ST_HOLD && phase_done)
        idx_q <= idx_q + 3'd1;
      if (st_q == fcs_pkg::ST_RD && phase_done)
      begin
        rdat_q <= dq_in;
        rvld_q <= 1'b1;
        if (polls_q)
          fail_q <= !poll_ok;
      end
      if (st_q == fcs_pkg::ST_POLL && phase_done && (poll_ok || poll_lim))
        polls_q <= 1'b1;
    end
  end

  // ---------------------------------------------
  // flash pins
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ce_b    <= 1'b1;
      we_b    <= 1'b1;
      oe_b    <= 1'b1;
      addr    <= 20'h00000;
      dq_out  <= 16'h0000;
      dq_oe_b <= 1'b1;
    end
    else
    begin
      ce_b    <= (st_d == fcs_pkg::ST_IDLE);
      we_b    <= (st_d != fcs_pkg::ST_WE);
      oe_b    <= !(st_d == fcs_pkg::ST_RD || st_d == fcs_pkg::ST_POLL) || read_gap; // gap between status reads
      dq_oe_b <= !(st_d == fcs_pkg::ST_SETUP || st_d == fcs_pkg::ST_WE || st_d == fcs_pkg::ST_HOLD) || !cur_c.wr;
      addr    <= (st_d == fcs_pkg::ST_POLL || st_d == fcs_pkg::ST_RD) ? req_q.addr : cur_c.addr;
      dq_out  <= cur_c.data;
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  property p_we_oe_excl;
    @(posedge clk) disable iff (!rst_b) !(!we_b && !oe_b);
  endproperty
  a_we_oe_excl: assert property (p_we_oe_excl) else $error("write and read strobes together");

  property p_data_while_we;
    @(posedge clk) disable iff (!rst_b) $fell(we_b) |-> !dq_oe_b ##1 !dq_oe_b [*2] ##1 $rose(we_b) && !dq_oe_b;
  endproperty
  a_data_while_we: assert property (p_data_while_we) else $error("data not held across write strobe");

  property p_upper_zero;
    @(posedge clk) disable iff (!rst_b)
      (!we_b && req_q.op != fcs_pkg::OP_PROGRAM && req_q.op != fcs_pkg::OP_BYP_PROG) |-> dq_out[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper byte set on command cycle");

  property p_poll_addr;
    @(posedge clk) disable iff (!rst_b) (st_q == fcs_pkg::ST_POLL && !oe_b) |-> addr == req_q.addr;
  endproperty
  a_poll_addr: assert property (p_poll_addr) else $error("poll at wrong address");

  property p_reset_cyc;
    @(posedge clk) disable iff (!rst_b)
      (!we_b && req_q.op == fcs_pkg::OP_RESET) |-> dq_out[7:0] == `FCS_D_RESET;
  endproperty
  a_reset_cyc: assert property (p_reset_cyc) else $error("reset code wrong");

  property p_id_third;
    @(posedge clk) disable iff (!rst_b)
      (!we_b && req_q.op == fcs_pkg::OP_ID_ENTER && idx_q == 3'd2) |-> dq_out[7:0] == `FCS_D_ID && addr == `FCS_UNLOCK1;
  endproperty
  a_id_third: assert property (p_id_third) else $error("id entry third cycle wrong");

  property p_poll_after_last;
    @(posedge clk) disable iff (!rst_b)
      (st_q == fcs_pkg::ST_HOLD && phase_done && last_cyc && poll_op) |=> ##[1:2] !oe_b;
  endproperty
  a_poll_after_last: assert property (p_poll_after_last) else $error("polling read not started");

  property p_done_poll;
    @(posedge clk) disable iff (!rst_b) (rvld_q && polls_q && !fail_q) |-> rdat_q[`FCS_POLL_BIT] == poll_want;
  endproperty
  a_done_poll: assert property (p_done_poll) else $error("done without true polling bit");

  property p_reread;
    @(posedge clk) disable iff (!rst_b)
      (st_q == fcs_pkg::ST_POLL && phase_done && (poll_ok || poll_lim)) |=> oe_b ##1 !oe_b ##2 rvld_q;
  endproperty
  a_reread: assert property (p_reread) else $error("no fresh read after status");
endmodule

// File: src/fcs_params.svh
// constants for the flash command sequencing controller
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_ADDR_W      20
`define FCS_DATA_W      16
`define FCS_UNLOCK1     20'h00555
`define FCS_UNLOCK2     20'h002AA
`define FCS_QUERY_ADDR  20'h00055
`define FCS_PROT_OFS    20'h00002
`define FCS_SECT_LSB    12
`define FCS_D_AA        8'hAA
`define FCS_D_55        8'h55
`define FCS_D_ID        8'h90
`define FCS_D_QUERY     8'h98
`define FCS_D_PROG      8'hA0
`define FCS_D_BYPASS    8'h20
`define FCS_D_SETUP     8'h80
`define FCS_D_CHIP      8'h10
`define FCS_D_SECT      8'h30
`define FCS_D_SUSP      8'hB0
`define FCS_D_RESET     8'hF0
`define FCS_D_ZERO      8'h00
`define FCS_POLL_BIT    7
`define FCS_LIMIT_BIT   5
`define FCS_CLK_NS      20
`define FCS_PHASE_NS    60
`define FCS_PHASE_CYC   ((`FCS_PHASE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`endif

// File: src/fcs_pkg.sv
// types for the flash command sequencing controller
package fcs_pkg;
  typedef enum logic [3:0]
  {
    OP_READ     = 4'h0,
    OP_RESET    = 4'h1,
    OP_ID_ENTER = 4'h2,
    OP_QUERY    = 4'h3,
    OP_PROGRAM  = 4'h4,
    OP_BYP_ENT  = 4'h5,
    OP_BYP_PROG = 4'h6,
    OP_BYP_EXIT = 4'h7,
    OP_CHIP_ER  = 4'h8,
    OP_SECT_ER  = 4'h9,
    OP_SUSPEND  = 4'hA,
    OP_RESUME   = 4'hB,
    OP_SECT_ADD = 4'hC
  } fcs_op_e;

  typedef struct packed
  {
    fcs_op_e     op;
    logic [19:0] addr;
    logic [15:0] data;
  } fcs_req_s;

  typedef struct packed
  {
    logic [19:0] addr;
    logic [15:0] data;
    logic        wr;
  } fcs_cyc_s;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_WE    = 3'h2,
    ST_HOLD  = 3'h3,
    ST_RD    = 3'h4,
    ST_POLL  = 3'h5
  } fcs_st_e;
endpackage

// File: test/fcs_ctrl_tb_top.sv
// self-checking bench for the flash command controller
module fcs_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk       = 1'b0;
  logic              rst_b     = 1'b0;
  logic              req_valid = 1'b0;
  fcs_pkg::fcs_req_s req       = '0;
  logic              req_ready;
  logic              rsp_valid;
  logic              rsp_fail;
  logic              ce_b;
  logic              we_b;
  logic              oe_b;
  logic              dq_oe_b;
  logic              gf;
  logic [19:0]       addr;
  logic [15:0]       rsp_data;
  logic [15:0]       dq_out;
  logic [15:0]       dq_in;
  logic [15:0]       got;
  int                bad_count = 0;
  int                n_checks  = 0;

  always #10 clk = ~clk;

  fcs_ctrl fcs_ctrl_inst (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail), .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b),
    .addr(addr), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .dq_in(dq_in));

  fcs_flash_model #(.QRY(16'h0E0E)) fcs_flash_model_inst (.ce_b(ce_b), .we_b(we_b), .oe_b(oe_b), .addr(addr),
    .dq_out(dq_out), .dq_in(dq_in));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic op(input fcs_pkg::fcs_op_e o, input logic [19:0] a, input logic [15:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req       = '{o, a, d};
    got       = 'x;
    gf        = 1'bx;
    @(negedge clk);
    req_valid = 1'b0;
    while (req_ready !== 1'b1)
    begin
      @(negedge clk);
      if (rsp_valid === 1'b1)
      begin
        got = rsp_data;
        gf  = rsp_fail;
      end
    end
  endtask

  task automatic ans(input logic [15:0] e, input logic f);
    chk(got, e);
    chk({15'h0000, gf}, {15'h0000, f});
  endtask

  task automatic rd(input logic [19:0] a, input logic [15:0] e);
    op(fcs_pkg::OP_READ, a, 16'h0000);
    chk(got, e);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_prog();
    op(fcs_pkg::OP_PROGRAM, 20'h00010, 16'h1234);
    ans(16'h1234, 1'b0);
    op(fcs_pkg::OP_PROGRAM, 20'h01000, 16'h0055);
    rd(20'h00010, 16'h1234);
  endtask

  task automatic t_byp_id();
    op(fcs_pkg::OP_BYP_ENT, 20'h00555, 16'h0000);
    op(fcs_pkg::OP_BYP_PROG, 20'h00020, 16'hA55A);
    ans(16'hA55A, 1'b0);
    op(fcs_pkg::OP_BYP_EXIT, 20'h00000, 16'h0000);
    op(fcs_pkg::OP_ID_ENTER, 20'h00555, 16'h0000);
    rd(20'h05002, 16'h0001);
    rd(20'h01002, 16'h0000);
    op(fcs_pkg::OP_RESET, 20'h00000, 16'h0000);
    rd(20'h00020, 16'hA55A);
  endtask

  task automatic t_erase();
    op(fcs_pkg::OP_SECT_ER, 20'h00010, 16'h0000);
    ans(16'hFFFF, 1'b0);
    rd(20'h00020, 16'hFFFF);
    rd(20'h01000, 16'h0055);
    op(fcs_pkg::OP_SUSPEND, 20'h00000, 16'h0000);
    op(fcs_pkg::OP_RESUME, 20'h00000, 16'h0000);
    rd(20'h01000, 16'h0055);
    op(fcs_pkg::OP_SECT_ADD, 20'h01000, 16'h0000);
    rd(20'h01000, 16'h0055);
    op(fcs_pkg::OP_QUERY, 20'h00055, 16'h0000);
    rd(20'h00010, 16'h0E0E);
    op(fcs_pkg::OP_RESET, 20'h00000, 16'h0000);
  endtask

  task automatic t_fail();
    op(fcs_pkg::OP_PROGRAM, 20'h01000, 16'h00FF);
    ans(16'h0020, 1'b1);
    op(fcs_pkg::OP_RESET, 20'h00000, 16'h0000);
    rd(20'h01000, 16'h0055);
    op(fcs_pkg::OP_PROGRAM, 20'h05000, 16'h0080);
    ans(16'hFFFF, 1'b0);
    op(fcs_pkg::OP_CHIP_ER, 20'h01000, 16'h0000);
    ans(16'hFFFF, 1'b0);
    rd(20'h01000, 16'hFFFF);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_prog();
    t_byp_id();
    t_erase();
    t_fail();
    report_and_stop();
  end

  initial
  begin
    #1000000;
    bad_count++;
    report_and_stop();
  end
endmodule

// File: test/fcs_flash_model.sv
// behavioural parallel flash answering the controller pins
module fcs_flash_model
#(
  parameter int          PBUSY = 3,
  parameter logic [7:0]  PROT  = 8'h05,
  parameter logic [15:0] MAKER = 16'h00A5,  // arbitrary value
  parameter logic [15:0] QRY   = 16'h0E0E
)
(
  // flash pins
  input  wire logic        ce_b,
  input  wire logic        we_b,
  input  wire logic        oe_b,
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dq_out,
  output wire logic [15:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // modes: 0 array 1 id 2 query 3 prog 4 erase 5 susp 6 bypass
  // ----------------------------------------
  logic [15:0] mem [int];
  logic [19:0] a_q;
  logic [15:0] pd;
  logic [15:0] v    = '0;
  logic [15:0] last = '0;
  logic        fail = 1'b0;
  int          mode = 0;
  int          pm   = 0;
  int          seq  = 0;
  int          busy = 0;

  function automatic logic [15:0] mv(input int k);
    return mem.exists(k) ? mem[k] : 16'hFFFF;
  endfunction

  function automatic logic [15:0] look();
    if (mode == 3)
      return {8'h00, ~pd[7], 1'b0, fail, 5'h00};
    if (mode == 4)
      return 16'h0000;
    if (mode == 1)
      return addr[7:0] == 8'h02 ? {15'h0000, addr[19:12] == PROT} : MAKER;
    if (mode == 2)
      return QRY;
    return mv(int'(addr));
  endfunction

  task automatic prog(input logic [15:0] d);
    logic lk;
    lk   = a_q[19:12] == PROT;
    pd   = d;
    pm   = mode;
    mode = 3;
    busy = PBUSY;
    seq  = 0;
    fail = !lk && |(d & ~mv(int'(a_q)));
    if (!lk && !fail)  // locked sector untouched
      mem[int'(a_q)] = d;
  endtask

  task automatic erase(input logic [7:0] c);
    seq = 0;
    if (c == 8'h10 || c == 8'h30)
    begin
      foreach (mem[k])
        if (k[19:12] != PROT && (c == 8'h10 || k[19:12] == a_q[19:12]))
          mem[k] = 16'hFFFF;
      mode = 4;
      busy = PBUSY;
    end
  endtask

  task automatic wr(input logic [15:0] d);
    logic [7:0] c;
    logic       u1;
    logic       u2;
    int         n;
    c  = d[7:0];  // upper byte ignored
    u1 = a_q[10:0] == 11'h555;  // high address ignored
    u2 = a_q[10:0] == 11'h2AA;
    if (mode == 4)
    begin
      if (c == 8'hB0)
        mode = 5;
      else if (c == 8'h30 && busy == PBUSY)  // extra sector before first status read
        erase(c);
    end
    else if (c == 8'hF0)
    begin
      mode = mode == 5 ? 5 : 0;
      seq  = 0;
      fail = 1'b0;
    end
    else if (mode == 6)
    begin
      n = seq == 9 ? 0 : c == 8'hA0 ? 9 : c == 8'h90 ? 8 : 0;
      if (seq == 9)
        prog(d);
      if (seq == 8 && c == 8'h00)
        mode = 0;
      seq = n;
    end
    else if (mode != 3)  // array, id, query, suspended
    begin
      if (seq == 0 && c == 8'h98 && a_q[10:0] == 11'h055 && mode < 2)
        mode = 2;
      if (seq == 0 && c == 8'h30 && mode == 5)
        mode = 4;
      if (seq == 2 && u1 && c == 8'h90)
        mode = 1;
      if (seq == 2 && u1 && c == 8'h20)
        mode = 6;
      case (seq)
        0: seq = c == 8'hAA && u1 ? 1 : 0;
        1: seq = c == 8'h55 && u2 ? 2 : 0;
        2: seq = !u1 ? 0 : c == 8'hA0 ? 3 : c == 8'h80 ? 4 : 0;
        3: prog(d);
        4: seq = c == 8'hAA && u1 ? 5 : 0;
        5: seq = c == 8'h55 && u2 ? 6 : 0;
        default: erase(c);
      endcase
    end
  endtask

  always @(negedge we_b or negedge ce_b)
    if (!we_b && !ce_b)  // address at the later fall
      a_q = addr;

  always @(posedge we_b or posedge ce_b)
    if (we_b ^ ce_b)  // data at the earlier rise
      wr(dq_out);

  always @(negedge oe_b)
    if (!ce_b)
      v = look();

  always @(posedge oe_b)
  begin
    last = v;
    if (busy > 0 && !fail)
      busy--;
    if (busy == 0 && (mode == 3 || mode == 4))
      mode = mode == 3 ? pm : 0;
  end

  // released bus shows the inverse of the last word
  assign dq_in = !oe_b && !ce_b ? v : ~last;
endmodule
